// ### rtl/crma_host.sv
// requester end: builds config register request messages and parses replies
`timescale 1ns/1ps
module crma_host import crma_pkg::*; #(
    parameter int PBYTES_MAX = CRMA_PBYTES_MAX
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        cmd_valid,
    input  wire crma_cmd_s   cmd,
    output logic             cmd_ready,
    output logic             tx_valid,
    output crma_tok_s        tx_tok,
    input  wire logic        tx_ready,
    output logic [31:0]      tx_dest,
    input  wire logic        rx_valid,
    input  wire crma_tok_s   rx_tok,
    output logic             rx_ready,
    output logic             done,
    output logic             ok,
    output logic [31:0]      rd_data,
    output logic [31:0]      ps_res_id
);
    initial begin
        if (PBYTES_MAX < 1 || PBYTES_MAX > 4) $error("crma_host: PBYTES_MAX must be 1..4");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} crma_state_e;

    crma_state_e state_r;
    crma_cmd_s   cmd_r;
    logic [3:0]  idx_r;
    logic [3:0]  rcnt_r;
    logic        head_r;
    logic        ack_r;
    logic        bad_r;
    logic        cmd_ready_r;
    logic        rx_ready_r;
    logic        done_r;
    logic        ok_r;
    logic [31:0] rd_data_r;
    logic [31:0] dest_r;
    logic [31:0] ps_r;
    crma_tok_s   tok_nxt;
    logic        buf_in_ready;

    ////////////////////////////////////////////////////////////////////////
    // message layout decode
    wire        is_per   = cmd_r.kind == CRMA_PERIPH;
    wire [3:0]  n_data   = cmd_r.write ? (is_per ? cmd_r.size[3:0] : CRMA_CFG_BYTES) : 4'h0;
    wire [3:0]  n_rd     = is_per ? cmd_r.size[3:0] : CRMA_CFG_BYTES;
    wire [3:0]  end_idx  = CRMA_IDX_DATA + n_data;
    wire [3:0]  k_byte   = idx_r - CRMA_IDX_DATA;
    wire [3:0]  b_byte   = n_data - 4'h1 - k_byte;
    wire [7:0]  data_byt = cmd_r.data[{b_byte[1:0], 3'b000} +: 8];
    wire [1:0]  r_sel    = 2'(CRMA_IDX_REG - idx_r - 4'h1);
    wire [7:0]  rply_byt = cmd_r.reply_id[{r_sel, 3'b000} +: 8];
    wire [7:0]  opcode   = cmd_r.write ? (is_per ? CRMA_TOK_WR_PER : CRMA_TOK_WR_CFG)
                                       : (is_per ? CRMA_TOK_RD_PER : CRMA_TOK_RD_CFG);
    wire        suppress = cmd_r.write && cmd_r.reply_id[7:0] == CRMA_NO_REPLY;
    wire        at_end   = idx_r == end_idx;
    wire        push     = state_r == ST_SEND && buf_in_ready;
    wire        rx_take  = rx_valid && rx_ready_r;
    wire        take     = cmd_valid && cmd_ready_r;
    wire        too_big  = cmd.kind == CRMA_PERIPH && cmd.size > 8'(PBYTES_MAX);
    wire [31:0] ps_id    = 32'(cmd.reg_num) << CRMA_PS_SHIFT | 32'(CRMA_PS_RES_TYPE);
    wire        rx_end   = rx_tok.ctrl && rx_tok.val == CRMA_TOK_END;
    wire        rx_good  = ack_r && !bad_r && (cmd_r.write ? rcnt_r == 4'h0 : rcnt_r == n_rd);

    logic [31:0] dest_nxt;
    always_comb begin
        case (cmd.kind)
            CRMA_TILE:   dest_nxt = {cmd.node_id, CRMA_DEST_TILE};
            CRMA_NODE:   dest_nxt = {cmd.node_id, CRMA_DEST_NODE};
            CRMA_PERIPH: dest_nxt = {cmd.node_id, cmd.sub_id, CRMA_DEST_PER};
            default:     dest_nxt = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // token select by position
    always_comb begin
        tok_nxt = '{ctrl: 1'b0, val: 8'h00};
        if (idx_r == 4'h0) begin
            tok_nxt = '{ctrl: 1'b1, val: opcode};
        end else if (idx_r < CRMA_IDX_REG) begin
            tok_nxt.val = rply_byt;
        end else if (idx_r == CRMA_IDX_REG) begin
            tok_nxt.val = is_per ? cmd_r.reg_num[7:0] : cmd_r.reg_num[15:8];
        end else if (idx_r < CRMA_IDX_DATA) begin
            tok_nxt.val = is_per ? cmd_r.size : cmd_r.reg_num[7:0];
        end else if (!at_end) begin
            tok_nxt.val = data_byt;
        end else begin
            tok_nxt = '{ctrl: 1'b1, val: CRMA_TOK_END};
        end
    end

    crma_buf2 #(
        .WIDTH     ($bits(crma_tok_s))
    ) u_txbuf (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (state_r == ST_SEND),
        .in_data   (tok_nxt),
        .in_ready  (buf_in_ready),
        .out_valid (tx_valid),
        .out_data  (tx_tok),
        .out_ready (tx_ready)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r     <= ST_IDLE;
            cmd_r       <= '0;
            idx_r       <= 4'h0;
            cmd_ready_r <= 1'b0;
            rx_ready_r  <= 1'b0;
            done_r      <= 1'b0;
            ok_r        <= 1'b0;
            dest_r      <= 32'h0000_0000;
            ps_r        <= 32'h0000_0000;
        end else begin
            done_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    cmd_ready_r <= 1'b1;
                    if (take) begin
                        cmd_r       <= cmd;
                        idx_r       <= 4'h0;
                        cmd_ready_r <= 1'b0;
                        if (cmd.kind == CRMA_PSTAT) begin
                            ps_r   <= ps_id;
                            done_r <= 1'b1;
                            ok_r   <= 1'b1;
                        end else if (too_big) begin
                            done_r <= 1'b1;
                            ok_r   <= 1'b0;
                        end else begin
                            dest_r  <= dest_nxt;
                            state_r <= ST_SEND;
                        end
                    end
                end
                ST_SEND: begin
                    if (push && at_end) begin
                        if (suppress) begin
                            state_r <= ST_IDLE;
                            done_r  <= 1'b1;
                            ok_r    <= 1'b1;
                        end else begin
                            state_r    <= ST_WAIT;
                            rx_ready_r <= 1'b1;
                        end
                    end else if (push) begin
                        idx_r <= idx_r + 4'h1;
                    end
                end
                ST_WAIT: begin
                    if (rx_take && head_r && rx_end) begin
                        state_r    <= ST_IDLE;
                        rx_ready_r <= 1'b0;
                        done_r     <= 1'b1;
                        ok_r       <= rx_good;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reply parser
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            head_r    <= 1'b0;
            ack_r     <= 1'b0;
            bad_r     <= 1'b0;
            rcnt_r    <= 4'h0;
            rd_data_r <= 32'h0000_0000;
        end else if (state_r != ST_WAIT) begin
            head_r <= 1'b0;
            ack_r  <= 1'b0;
            bad_r  <= 1'b0;
            rcnt_r <= 4'h0;
        end else if (rx_take && !head_r) begin
            head_r <= 1'b1;
            ack_r  <= rx_tok.ctrl && rx_tok.val == CRMA_TOK_ACK;
            bad_r  <= !(rx_tok.ctrl && (rx_tok.val == CRMA_TOK_ACK
                                     || rx_tok.val == CRMA_TOK_NAK));
        end else if (rx_take && !rx_tok.ctrl) begin
            rd_data_r <= {rd_data_r[23:0], rx_tok.val};
            rcnt_r    <= rcnt_r + 4'h1;
            if (!ack_r || cmd_r.write || rcnt_r >= n_rd) begin
                bad_r <= 1'b1;
            end
        end else if (rx_take && !rx_end) begin
            bad_r <= 1'b1;
        end
    end

    assign cmd_ready = cmd_ready_r;
    assign rx_ready  = rx_ready_r;
    assign done      = done_r;
    assign ok        = ok_r;
    assign rd_data   = rd_data_r;
    assign tx_dest   = dest_r;
    assign ps_res_id = ps_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_ps_take;
        take && cmd.kind == CRMA_PSTAT;
    endsequence

    sequence s_last_push;
        push && at_end;
    endsequence

    a_ps_res_id: assert property (@(posedge clk) disable iff (!rst_n)
        s_ps_take |=> ps_res_id == ({$past(cmd.reg_num), 8'h00} | 32'h0b) && done)
        else $error("status resource id wrong");
    a_suppress_idle: assert property (@(posedge clk) disable iff (!rst_n)
        s_last_push ##0 suppress |=> state_r == ST_IDLE && done && ok && !rx_ready)
        else $error("reply not suppressed");
    a_reply_wait: assert property (@(posedge clk) disable iff (!rst_n)
        s_last_push ##0 !suppress |=> state_r == ST_WAIT && rx_ready)
        else $error("reply not awaited");
    a_reply_msb: assert property (@(posedge clk) disable iff (!rst_n)
        push && idx_r == CRMA_IDX_REPLY |-> !tok_nxt.ctrl && tok_nxt.val == cmd_r.reply_id[23:16])
        else $error("reply id not msb first");
    a_cfg_reg_msb: assert property (@(posedge clk) disable iff (!rst_n)
        push && !is_per && idx_r == CRMA_IDX_REG |-> tok_nxt.val == cmd_r.reg_num[15:8])
        else $error("config register number not msb first");
    a_open_token: assert property (@(posedge clk) disable iff (!rst_n)
        push && idx_r == 4'h0 && !is_per |-> tok_nxt.ctrl
            && tok_nxt.val == (cmd_r.write ? 8'd192 : 8'd193))
        else $error("config opening token wrong");
    a_per_open: assert property (@(posedge clk) disable iff (!rst_n)
        push && idx_r == 4'h0 && is_per |-> tok_nxt.val == (cmd_r.write ? 8'd36 : 8'd37))
        else $error("peripheral opening token wrong");
    a_close_len: assert property (@(posedge clk) disable iff (!rst_n)
        s_last_push |-> tok_nxt.ctrl && tok_nxt.val == 8'd1
            && idx_r == 4'd6 + (cmd_r.write ? (is_per ? cmd_r.size[3:0] : 4'd4) : 4'd0))
        else $error("closing token misplaced");
    a_dest_pattern: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == ST_SEND |-> (cmd_r.kind == CRMA_TILE   && tx_dest[15:0] == 16'hc20c)
                            || (cmd_r.kind == CRMA_NODE   && tx_dest[15:0] == 16'hc30c)
                            || (cmd_r.kind == CRMA_PERIPH && tx_dest[7:0] == 8'h02
                                && tx_dest[15:8] == cmd_r.sub_id))
        else $error("destination pattern wrong");
endmodule // crma_host

// ### common/crma_pkg.sv
// package: token codes, destination patterns, message layout for config register access
package crma_pkg;
    localparam logic [7:0]  CRMA_TOK_WR_CFG   = 8'hc0;
    localparam logic [7:0]  CRMA_TOK_RD_CFG   = 8'hc1;
    localparam logic [7:0]  CRMA_TOK_WR_PER   = 8'h24;
    localparam logic [7:0]  CRMA_TOK_RD_PER   = 8'h25;
    localparam logic [7:0]  CRMA_TOK_END      = 8'h01;
    localparam logic [7:0]  CRMA_TOK_ACK      = 8'h03;
    localparam logic [7:0]  CRMA_TOK_NAK      = 8'h04;
    localparam logic [7:0]  CRMA_NO_REPLY     = 8'hff;
    localparam logic [15:0] CRMA_DEST_TILE    = 16'hc20c;
    localparam logic [15:0] CRMA_DEST_NODE    = 16'hc30c;
    localparam logic [7:0]  CRMA_DEST_PER     = 8'h02;
    localparam logic [7:0]  CRMA_PS_RES_TYPE  = 8'h0b;
    localparam int          CRMA_PS_SHIFT     = 8;
    localparam logic [3:0]  CRMA_IDX_REPLY    = 4'h1;
    localparam logic [3:0]  CRMA_IDX_REG      = 4'h4;
    localparam logic [3:0]  CRMA_IDX_DATA     = 4'h6;
    localparam logic [3:0]  CRMA_CFG_BYTES    = 4'h4;
    localparam int          CRMA_PBYTES_MAX   = 4;

    typedef enum logic [1:0] {CRMA_TILE, CRMA_NODE, CRMA_PERIPH, CRMA_PSTAT} crma_kind_e;

    typedef struct packed {
        logic       ctrl;
        logic [7:0] val;
    } crma_tok_s;

    typedef struct packed {
        crma_kind_e  kind;
        logic        write;
        logic [15:0] node_id;
        logic [7:0]  sub_id;
        logic [15:0] reg_num;
        logic [23:0] reply_id;
        logic [31:0] data;
        logic [7:0]  size;
    } crma_cmd_s;
endpackage

// ### rtl/crma_buf2.sv
// two-entry token buffer with valid and ready on both sides
`timescale 1ns/1ps
module crma_buf2 #(
    parameter int WIDTH = 9
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    initial begin
        if (WIDTH < 1) $error("crma_buf2: WIDTH must be positive");
    end

    logic [WIDTH-1:0] mem_r [0:1];
    logic [1:0]       vld_r;
    wire              pop  = vld_r[0] & out_ready;
    wire              push = in_valid & ~vld_r[1];
    wire              wsel = pop ? vld_r[1] : vld_r[0];

    assign in_ready  = ~vld_r[1];
    assign out_valid = vld_r[0];
    assign out_data  = mem_r[0];

    ////////////////////////////////////////////////////////////////////////
    // shift on pop, write at first free slot
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vld_r    <= 2'b00;
            mem_r[0] <= '0;
            mem_r[1] <= '0;
        end else begin
            if (pop) begin
                mem_r[0] <= mem_r[1];
            end
            if (push) begin
                mem_r[wsel] <= in_data;
            end
            case ({push, pop})
                2'b10:   vld_r <= {vld_r[0], 1'b1};
                2'b01:   vld_r <= {1'b0, vld_r[1]};
                default: vld_r <= vld_r;
            endcase
        end
    end

    a_no_overrun: assert property (@(posedge clk) disable iff (!rst_n)
        vld_r[1] |-> vld_r[0]) else $error("buffer slot order broken");
endmodule // crma_buf2

// ### testbench/crma_dev_model.sv
// device-side model: parses request messages, holds registers, sends replies
`timescale 1ns/1ps
module crma_dev_model import crma_pkg::*; (
    input  wire logic        clk,
    input  wire logic        stall_en,
    input  wire logic        tx_valid,
    input  wire crma_tok_s   tx_tok,
    output logic             tx_ready,
    input  wire logic [31:0] tx_dest,
    output logic             rx_valid,
    output crma_tok_s        rx_tok,
    input  wire logic        rx_ready,
    output logic [7:0]       m_tok,
    output logic [23:0]      m_rid,
    output logic [31:0]      m_data,
    output int               m_len
);
    logic [7:0]  msg[$];
    logic [31:0] cfg[0:511];
    logic [31:0] pr[0:255];
    ////////////////////////////////////////////////////////////////////////////
    task automatic put(logic c, logic [7:0] v);
        @(negedge clk);
        rx_valid <= 1'b1;
        rx_tok   <= '{ctrl: c, val: v};
        do @(posedge clk); while (rx_ready !== 1'b1);
    endtask
    task automatic serve();
        logic bad;
        int   nd;
        m_tok  = msg[0];
        m_len  = msg.size();
        m_rid  = {msg[1], msg[2], msg[3]};
        nd     = m_len - 7;
        m_data = '0;
        for (int i = 6; i < m_len - 1; i++) m_data = {m_data[23:0], msg[i]};
        case (msg[0])
            CRMA_TOK_WR_CFG: bad = nd != 4 || msg[4] != 8'h00;
            CRMA_TOK_RD_CFG: bad = nd != 0 || msg[4] != 8'h00;
            CRMA_TOK_WR_PER: bad = nd != msg[5] || msg[4][7];
            CRMA_TOK_RD_PER: bad = nd != 0 || msg[4][7] || msg[5] > 8'h04;
            default:         bad = 1'b1;
        endcase
        if (!bad && msg[0] == CRMA_TOK_WR_CFG) cfg[{tx_dest[8], msg[5]}] = m_data;
        if (!bad && msg[0] == CRMA_TOK_WR_PER) pr[msg[4]] = m_data;
        if (msg[0] inside {CRMA_TOK_WR_CFG, CRMA_TOK_WR_PER} && m_rid[7:0] == CRMA_NO_REPLY) begin
            msg.delete();
        end else if (bad) begin
            put(1'b1, CRMA_TOK_NAK);
            put(1'b1, CRMA_TOK_END);
        end else begin
            put(1'b1, CRMA_TOK_ACK);
            if (msg[0] == CRMA_TOK_RD_CFG)
                for (int i = 3; i >= 0; i--) put(1'b0, cfg[{tx_dest[8], msg[5]}][8*i +: 8]);
            if (msg[0] == CRMA_TOK_RD_PER)
                for (int i = msg[5] - 1; i >= 0; i--) put(1'b0, pr[msg[4]][8*i +: 8]);
            put(1'b1, CRMA_TOK_END);
        end
        msg.delete();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_tok   = '0;
        foreach (cfg[i]) cfg[i] = '0;
        foreach (pr[i]) pr[i] = '0;
        forever begin
            @(negedge clk);
            rx_valid <= 1'b0;
            rx_tok   <= crma_tok_s'(~rx_tok);
            tx_ready <= (stall_en !== 1'b1) || ($urandom_range(0, 1) == 1);
            @(posedge clk);
            if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
                msg.push_back(tx_tok.val);
                if (tx_tok.ctrl === 1'b1 && tx_tok.val === CRMA_TOK_END) serve();
            end
        end
    end
endmodule // crma_dev_model

// ### testbench/testbench.sv
// self-checking bench for the config register request controller
`timescale 1ns/1ps
module testbench import crma_pkg::*;;
    localparam int PB = 4;
    typedef struct {crma_cmd_s c; logic ok; logic [31:0] rd; logic chk;} crma_exp_s;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cmd_valid = 1'b0;
    logic        stall_en = 1'b0;
    crma_cmd_s   cmd = '0;
    logic        cmd_ready, tx_valid, tx_ready, rx_valid, rx_ready, done, ok;
    crma_tok_s   tx_tok, rx_tok;
    logic [31:0] tx_dest, rd_data, ps_res_id, m_data, d;
    logic [23:0] m_rid;
    logic [7:0]  m_tok;
    int          m_len, failures = 0, n_tests = 0, cyc = 0;
    crma_exp_s   exq[$];
    crma_exp_s   e;
    crma_kind_e  k;
    logic [15:0] r;
    always #5 clk = ~clk;
    crma_host #(.PBYTES_MAX(PB)) dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .tx_valid(tx_valid), .tx_tok(tx_tok),
        .tx_ready(tx_ready), .tx_dest(tx_dest), .rx_valid(rx_valid), .rx_tok(rx_tok),
        .rx_ready(rx_ready), .done(done), .ok(ok), .rd_data(rd_data), .ps_res_id(ps_res_id));
    crma_dev_model dev (.clk(clk), .stall_en(stall_en), .tx_valid(tx_valid), .tx_tok(tx_tok),
        .tx_ready(tx_ready), .tx_dest(tx_dest), .rx_valid(rx_valid), .rx_tok(rx_tok),
        .rx_ready(rx_ready), .m_tok(m_tok), .m_rid(m_rid), .m_data(m_data), .m_len(m_len));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
            failures++;
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    function automatic crma_cmd_s mk(crma_kind_e kd, logic w, logic [15:0] rg,
                                     logic [31:0] dt, logic [7:0] sz, logic q);
        crma_cmd_s c;
        c.kind     = kd;
        c.write    = w;
        c.node_id  = 16'($urandom);
        c.sub_id   = 8'($urandom);
        c.reg_num  = rg;
        c.reply_id = {16'($urandom), q ? CRMA_NO_REPLY : 8'h3c};
        c.data     = dt;
        c.size     = sz;
        return c;
    endfunction
    function automatic logic [31:0] msk_of(crma_cmd_s c);
        if (c.kind == CRMA_PERIPH && c.size < 8'h04) return (32'h1 << (8 * c.size)) - 32'h1;
        return 32'hffffffff;
    endfunction
    function automatic logic [31:0] dest_of(crma_cmd_s c);
        if (c.kind == CRMA_TILE) return {c.node_id, CRMA_DEST_TILE};
        if (c.kind == CRMA_NODE) return {c.node_id, CRMA_DEST_NODE};
        return {c.node_id, c.sub_id, CRMA_DEST_PER};
    endfunction
    function automatic logic [7:0] tok_of(crma_cmd_s c);
        if (c.kind == CRMA_PERIPH) return c.write ? CRMA_TOK_WR_PER : CRMA_TOK_RD_PER;
        return c.write ? CRMA_TOK_WR_CFG : CRMA_TOK_RD_CFG;
    endfunction
    task automatic op(crma_cmd_s c, logic eok, logic [31:0] erd);
        crma_exp_s x;
        x.c   = c;
        x.ok  = eok;
        x.rd  = erd;
        x.chk = !(c.kind == CRMA_PSTAT || (c.kind == CRMA_PERIPH && c.size > PB)
                  || (c.write && c.reply_id[7:0] == CRMA_NO_REPLY));
        exq.push_back(x);
        @(negedge clk);
        cmd       <= c;
        cmd_valid <= 1'b1;
        do @(posedge clk); while (cmd_ready !== 1'b1);
        @(negedge clk);
        cmd_valid <= 1'b0;
        cmd       <= mk(CRMA_NODE, 1'b1, 16'($urandom), $urandom, 8'($urandom), 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        if (done === 1'b1) begin
            e = exq.pop_front();
            check("ok", 32'(ok), 32'(e.ok));
            if (e.c.kind == CRMA_PSTAT)
                check("res id", ps_res_id, {8'h00, e.c.reg_num, CRMA_PS_RES_TYPE});
            else if (e.ok && !e.c.write)
                check("rd data", rd_data & msk_of(e.c), e.rd & msk_of(e.c));
            if (e.chk) begin
                check("dest", tx_dest, dest_of(e.c));
                check("reply id", 32'(m_rid), 32'(e.c.reply_id));
                check("head", 32'(m_tok), 32'(tok_of(e.c)));
                check("length", m_len, 7 + (e.c.write ? (e.c.kind == CRMA_PERIPH ?
                      32'(e.c.size) : 4) : 0));
                if (e.c.write) check("wr data", m_data, e.c.data & msk_of(e.c));
            end
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        d = $urandom(32'h0b3f7f9f);
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst_n <= 1'b1;
        d = $urandom;
        op(mk(CRMA_TILE, 1'b1, 16'h0005, d, 8'h00, 1'b0), 1'b1, 0);
        op(mk(CRMA_TILE, 1'b0, 16'h0005, 0, 8'h00, 1'b0), 1'b1, d);
        op(mk(CRMA_NODE, 1'b1, 16'h0005, ~d, 8'h00, 1'b1), 1'b1, 0);
        op(mk(CRMA_NODE, 0, 16'h0005, 0, 8'h00, 1'b0), 1'b1, ~d);
        op(mk(CRMA_TILE, 0, 16'h0005, 0, 8'h00, 1'b0), 1'b1, d);
        op(mk(CRMA_TILE, 0, 16'h0123, 0, 8'h00, 1'b0), 1'b0, 0);
        op(mk(CRMA_NODE, 1, 16'h0200, d, 8'h00, 1'b0), 1'b0, 0);
        $display("test config access done");
        for (int n = 1; n <= PB + 1; n++) begin
            d = $urandom;
            op(mk(CRMA_PERIPH, 1, 16'(8'h10 + n), d, 8'(n), 0), n <= PB, 0);
            op(mk(CRMA_PERIPH, 0, 16'(8'h10 + n), 0, 8'(n), 0), n <= PB, d);
        end
        op(mk(CRMA_PERIPH, 0, 16'h0090, 0, 8'h01, 1'b0), 1'b0, 0);
        op(mk(CRMA_PSTAT, 0, 16'($urandom), 0, 8'h00, 1'b0), 1'b1, 0);
        $display("test peripheral and status done");
        stall_en <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            k = i[0] ? CRMA_NODE : CRMA_TILE;
            r = 16'($urandom_range(0, 255));
            d = $urandom;
            op(mk(k, 1'b1, r, d, 8'h00, i[1]), 1'b1, 0);
            op(mk(k, 1'b0, r, 0, 8'h00, 1'b0), 1'b1, d);
        end
        while (exq.size() != 0) @(negedge clk);
        $display("test stalled back-to-back done");
        print_verdict();
    end
endmodule // testbench
